// file: core/bgdc_pkg.sv
// Functional notes
// R1 - Special single-chip: enabled and active after reset
// R2 - Emulation modes: enabled, not active after reset
// R3 - Emulation modes: clock select resets to one
// R4 - Always present; firmware commands need enable
// R5 - Hardware commands run without active background
// R6 - Nine hardware commands using free bus cycles
// R7 - Fourteen firmware commands dispatched from ROM table
// R8 - Hardware commands work until stop mode
// R9 - Secured: block nonvolatile access, reduced command set
// R10 - Secured, special, erase failed: register space allowed
// R11 - Family ID byte readable at fixed address
// R12 - Completion handshake toward host, no fixed delays
// R13 - Same in all normal modes, no power controls
// R14 - Software sets wait behaviour and clock source
package bgdc_pkg;

  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CODE_W = 4;

  typedef enum logic [CODE_W-1:0] {
    HC_BACKGROUND,
    HC_ACK_ON,
    HC_ACK_OFF,
    HC_RD_BYTE,
    HC_RD_WORD,
    HC_WR_BYTE,
    HC_WR_WORD,
    HC_RD_DBG_BYTE,
    HC_WR_DBG_BYTE
  } bgdc_hw_cmd_e;

  localparam logic [CODE_W-1:0] HW_CMD_COUNT = 4'h9;
  localparam logic [CODE_W-1:0] FW_CMD_COUNT = 4'hE;

  // Address map of the global space seen by the debug unit
  localparam logic [ADDR_W-1:0] REG_SPACE_LO = 23'h000000;
  localparam logic [ADDR_W-1:0] REG_SPACE_HI = 23'h0007FF;
  localparam logic [ADDR_W-1:0] NVM_LO = 23'h400000;
  localparam logic [ADDR_W-1:0] NVM_HI = 23'h7FFEFF;
  localparam logic [ADDR_W-1:0] DBG_SPACE_LO = 23'h7FFF00;
  localparam logic [ADDR_W-1:0] FAMILY_ID_ADDR = 23'h7FFF0F;

  // Firmware dispatch table: one word per firmware command
  localparam logic [DATA_W-1:0] FW_TABLE_BASE = 16'hFF00;
  localparam logic [DATA_W-1:0] FW_ENTRY_STRIDE = 16'h0002;

  // Arbitrary value, no relation to any real part
  localparam logic [BYTE_W-1:0] FAMILY_ID_DEFAULT = 8'h5A;

endpackage

// file: core/bgdc_rom.sv
`timescale 1ns/1ps
`default_nettype none
module bgdc_rom
  import bgdc_pkg::*;
(
  // Lookup inputs
  input wire logic [CODE_W-1:0] fw_index,
  input wire logic [ADDR_W-1:0] addr,
  // Lookup results
  output logic [DATA_W-1:0] fw_entry,
  output logic id_hit,
  output logic [BYTE_W-1:0] id_byte
);

  always_comb begin
    fw_entry = FW_TABLE_BASE + DATA_W'(fw_index) * FW_ENTRY_STRIDE; // see R7
    id_hit = (addr == FAMILY_ID_ADDR); // see R11
    id_byte = FAMILY_ID_DEFAULT;
  end

endmodule
`default_nettype wire

// file: core/bgdc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module bgdc_ctrl
  import bgdc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Chip operating mode and security
  input wire logic mode_special_single_chip,
  input wire logic mode_emulation,
  input wire logic secured,
  input wire logic nvm_erase_test_failed,
  input wire logic wait_mode,
  input wire logic stop_mode,
  // Software controls
  input wire logic sw_enable_wr,
  input wire logic sw_enable_val,
  input wire logic sw_wait_run_wr,
  input wire logic sw_wait_run_val,
  input wire logic sw_clock_sel_wr,
  input wire logic sw_clock_sel_val,
  // Command from serial front end
  input wire logic cmd_valid,
  input wire logic cmd_is_fw,
  input wire logic [CODE_W-1:0] cmd_code,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  output logic cmd_ready,
  // Response and handshake
  output logic rsp_valid,
  output logic rsp_error,
  output logic [DATA_W-1:0] rsp_data,
  output logic ack_pulse,
  // System bus, free-cycle access
  input wire logic bus_free,
  input wire logic [DATA_W-1:0] bus_rdata,
  output logic bus_req,
  output logic bus_we,
  output logic bus_word,
  output logic [ADDR_W-1:0] bus_addr,
  output logic [DATA_W-1:0] bus_wdata,
  // Firmware dispatch
  input wire logic fw_done,
  input wire logic fw_exit,
  output logic fw_start,
  output logic [DATA_W-1:0] fw_entry,
  // Status
  output logic background_enabled,
  output logic background_active,
  output logic debug_clock_source_select,
  output logic wait_run_enable
);

  typedef enum logic [2:0] {
    ST_INIT,
    ST_IDLE,
    ST_WAIT_BUS,
    ST_RESP,
    ST_FW
  } bgdc_state_e;

  typedef struct packed {
    bgdc_state_e st;
    logic enabled;
    logic active;
    logic clk_sel;
    logic ack_en;
    logic wait_run;
    logic cmd_ready;
    logic is_wr;
    logic is_word;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic bus_req;
    logic rsp_valid;
    logic rsp_error;
    logic [DATA_W-1:0] rsp_data;
    logic ack_pulse;
    logic fw_start;
    logic [DATA_W-1:0] fw_entry;
  } bgdc_ctrl_s;

  bgdc_ctrl_s state_q;
  bgdc_ctrl_s state_d;

  logic [DATA_W-1:0] rom_entry;
  logic rom_id_hit;
  logic [BYTE_W-1:0] rom_id_byte;
  logic [ADDR_W-1:0] lookup_addr;

  // Debug-space byte commands carry only the low offset, so the ID lookup must see the full address
  assign lookup_addr = ((cmd_code == HC_RD_DBG_BYTE) || (cmd_code == HC_WR_DBG_BYTE)) ?
                       (DBG_SPACE_LO | cmd_addr) : cmd_addr; // see R11

  bgdc_rom u_rom (
    .fw_index(cmd_code),
    .addr(lookup_addr),
    .fw_entry(rom_entry),
    .id_hit(rom_id_hit),
    .id_byte(rom_id_byte)
  );

  function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Secured parts keep nonvolatile memory closed; erasure goes through the flash controller
  function automatic logic access_ok(input logic [ADDR_W-1:0] a, input logic sec, input logic ssc,
                                     input logic erase_fail);
    if (!sec) begin
      access_ok = 1'b1;
    end else if (in_range(a, NVM_LO, NVM_HI)) begin
      access_ok = 1'b0; // see R9
    end else if (in_range(a, REG_SPACE_LO, REG_SPACE_HI)) begin
      access_ok = ssc && erase_fail; // see R10
    end else begin
      access_ok = 1'b0; // see R9
    end
  endfunction

  always_comb begin
    logic halted;
    logic finish;
    logic fail;
    state_d = state_q;
    halted = 1'b0;
    finish = 1'b0;
    fail = 1'b0;
    state_d.bus_req = 1'b0;
    state_d.rsp_valid = 1'b0;
    state_d.rsp_error = 1'b0;
    state_d.ack_pulse = 1'b0;
    state_d.fw_start = 1'b0;

    // Only stop mode, or wait mode unless software has set wait_run, suspends the unit
    halted = stop_mode || (wait_mode && !state_q.wait_run); // see R8 see R13 see R14

    if (sw_enable_wr) begin
      state_d.enabled = sw_enable_val;
    end
    if (sw_wait_run_wr) begin
      state_d.wait_run = sw_wait_run_val; // see R14
    end
    if (sw_clock_sel_wr) begin
      state_d.clk_sel = sw_clock_sel_val; // see R14
    end

    case (state_q.st)
      ST_INIT: begin
        // Mode straps are sampled on the first clock after reset release
        state_d.enabled = mode_special_single_chip || mode_emulation; // see R1 see R2
        state_d.active = mode_special_single_chip; // see R1 see R2
        state_d.clk_sel = mode_emulation; // see R3
        state_d.st = ST_IDLE;
      end
      ST_IDLE: begin
        state_d.cmd_ready = !halted;
        if (cmd_valid && state_q.cmd_ready) begin
          state_d.cmd_ready = 1'b0;
          state_d.addr = cmd_addr;
          state_d.wdata = cmd_wdata;
          state_d.is_wr = 1'b0;
          state_d.is_word = 1'b0;
          if (cmd_is_fw) begin
            // Firmware needs an enabled, active and unsecured unit
            if (!state_q.enabled || !state_q.active || secured || cmd_code >= FW_CMD_COUNT) begin
              fail = 1'b1; // see R4 see R9
            end else begin
              state_d.fw_start = 1'b1; // see R7
              state_d.fw_entry = rom_entry;
              state_d.st = ST_FW;
            end
          end else if (cmd_code >= HW_CMD_COUNT) begin
            fail = 1'b1;
          end else begin
            // Hardware commands do not depend on the active state
            case (bgdc_hw_cmd_e'(cmd_code)) // see R5 see R6
              HC_BACKGROUND: begin
                if (state_q.enabled) begin
                  state_d.active = 1'b1;
                  finish = 1'b1;
                end else begin
                  fail = 1'b1;
                end
              end
              HC_ACK_ON: begin
                state_d.ack_en = 1'b1; // see R12
                finish = 1'b1;
              end
              HC_ACK_OFF: begin
                state_d.ack_en = 1'b0;
                finish = 1'b1;
              end
              default: begin
                state_d.is_wr = (cmd_code == HC_WR_BYTE) || (cmd_code == HC_WR_WORD) ||
                                (cmd_code == HC_WR_DBG_BYTE);
                state_d.is_word = (cmd_code == HC_RD_WORD) || (cmd_code == HC_WR_WORD);
                if ((cmd_code == HC_RD_DBG_BYTE) || (cmd_code == HC_WR_DBG_BYTE)) begin
                  state_d.addr = DBG_SPACE_LO | cmd_addr;
                end
                if (rom_id_hit && !state_d.is_wr && !state_d.is_word) begin
                  state_d.rsp_data = DATA_W'(rom_id_byte); // see R11
                  finish = 1'b1;
                end else if (!access_ok(state_d.addr, secured, mode_special_single_chip,
                                        nvm_erase_test_failed)) begin
                  fail = 1'b1; // see R9 see R10
                end else begin
                  state_d.st = ST_WAIT_BUS;
                end
              end
            endcase
          end
        end
      end
      ST_WAIT_BUS: begin
        // Steal a free cycle rather than stall the CPU
        if (bus_free && !stop_mode) begin
          state_d.bus_req = 1'b1; // see R6 see R8
          state_d.st = ST_RESP;
        end
      end
      ST_RESP: begin
        if (!state_q.is_wr) begin
          state_d.rsp_data = state_q.is_word ? bus_rdata : DATA_W'(bus_rdata[BYTE_W-1:0]);
        end
        finish = 1'b1;
      end
      ST_FW: begin
        if (fw_done) begin
          if (fw_exit) begin
            state_d.active = 1'b0;
          end
          finish = 1'b1;
        end
      end
      default: begin
        state_d.st = ST_IDLE;
      end
    endcase

    if (finish || fail) begin
      state_d.rsp_valid = 1'b1; // see R12
      state_d.rsp_error = fail;
      state_d.ack_pulse = state_q.ack_en && !fail; // see R12
      state_d.st = ST_IDLE;
      state_d.cmd_ready = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign cmd_ready = state_q.cmd_ready;
  assign rsp_valid = state_q.rsp_valid;
  assign rsp_error = state_q.rsp_error;
  assign rsp_data = state_q.rsp_data;
  assign ack_pulse = state_q.ack_pulse;
  assign bus_req = state_q.bus_req;
  assign bus_we = state_q.is_wr;
  assign bus_word = state_q.is_word;
  assign bus_addr = state_q.addr;
  assign bus_wdata = state_q.wdata;
  assign fw_start = state_q.fw_start;
  assign fw_entry = state_q.fw_entry;
  assign background_enabled = state_q.enabled;
  assign background_active = state_q.active;
  assign debug_clock_source_select = state_q.clk_sel;
  assign wait_run_enable = state_q.wait_run;

endmodule
`default_nettype wire

// file: sim/bgdc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module bgdc_ctrl_props
  import bgdc_pkg::*;
(
  // Watched ports
  input wire logic clk, rst_n, mode_special_single_chip, mode_emulation, secured,
  input wire logic wait_mode, stop_mode, cmd_valid, cmd_ready, cmd_is_fw, rsp_valid,
  input wire logic rsp_error, bus_free, bus_req, fw_start, background_enabled,
  input wire logic background_active, debug_clock_source_select, wait_run_enable,
  input wire logic [CODE_W-1:0] cmd_code,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] rsp_data, fw_entry
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic take = cmd_valid && cmd_ready;
  wire logic hw_bus = take && !cmd_is_fw && cmd_code >= 4'h3 && cmd_code <= 4'h6;
  property p_init;
    $rose(rst_n) |=> background_enabled == $past(mode_special_single_chip || mode_emulation)
      && background_active == $past(mode_special_single_chip)
      && debug_clock_source_select == $past(mode_emulation);
  endproperty
  a_init: assert property (p_init) else $error("bad reset state");
  property p_rsp;
    rsp_valid |=> !rsp_valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("long response");
  property p_free;
    bus_req |-> $past(bus_free) && !$past(stop_mode);
  endproperty
  a_free: assert property (p_free) else $error("bus taken when busy");
  // Three cycles, so a registered halt flag still has time to land
  property p_halt;
    (stop_mode || wait_mode && !wait_run_enable) [*3] |-> !cmd_ready;
  endproperty
  a_halt: assert property (p_halt) else $error("ready while halted");
  property p_fwref;
    take && cmd_is_fw && !background_active |=> rsp_valid && rsp_error && !fw_start;
  endproperty
  a_fwref: assert property (p_fwref) else $error("firmware not refused");
  property p_fwent;
    fw_start |-> fw_entry == FW_TABLE_BASE + FW_ENTRY_STRIDE * $past(cmd_code);
  endproperty
  a_fwent: assert property (p_fwent) else $error("bad table entry");
  property p_sec;
    hw_bus && secured && cmd_addr >= NVM_LO && cmd_addr <= NVM_HI |=> rsp_valid && rsp_error;
  endproperty
  a_sec: assert property (p_sec) else $error("secured access let through");
  property p_id;
    take && !cmd_is_fw && cmd_code == 4'h3 && cmd_addr == FAMILY_ID_ADDR && !secured
      |=> rsp_valid && rsp_data == {8'h00, FAMILY_ID_DEFAULT};
  endproperty
  a_id: assert property (p_id) else $error("bad family byte");
  c_fw: cover property (fw_start);
  c_bus: cover property (bus_req);
  c_err: cover property (rsp_valid && rsp_error);
endmodule
`default_nettype wire

// file: sim/bgdc_sys_model.sv
`timescale 1ns/1ps
`default_nettype none
module bgdc_sys_model
  import bgdc_pkg::*;
(
  // Clock, reset and bench control
  input wire logic clk, rst_n, exit_sel,
  // Bus and firmware side of the unit
  input wire logic bus_req, fw_start,
  input wire logic [ADDR_W-1:0] bus_addr,
  output logic bus_free, fw_done, fw_exit,
  output logic [DATA_W-1:0] bus_rdata
);
  logic [1:0] ph_q;
  logic [2:0] fw_q;
  logic req_q;
  always_ff @(posedge clk) begin
    ph_q <= rst_n ? ph_q + 2'h1 : 2'h0;
    req_q <= rst_n && bus_req;
    fw_q <= rst_n ? {fw_q[1:0], fw_start} : 3'h0;
  end
  // CPU owns three cycles of four, so the unit must wait for a gap
  assign bus_free = ph_q == 2'h3;
  // Outside an access the data lines churn, never a stale value
  assign bus_rdata = (bus_req || req_q) ? {~bus_addr[7:0], bus_addr[7:0]} : {8{ph_q}};
  assign fw_done = fw_q[2];
  assign fw_exit = fw_q[2] && exit_sel;
endmodule
`default_nettype wire

// file: sim/bgdc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bgdc_ctrl_tb;
  import bgdc_pkg::*;
  logic clk, rst_n, ssc, emul, secured, efail, wait_mode, stop_mode, exit_sel;
  logic wr_wait, wr_clk, sw_val, cmd_valid, cmd_is_fw, cmd_ready, rsp_valid, rsp_error, wr_en;
  logic bus_free, bus_req, fw_start, fw_done, fw_exit, en, act, csel, wrun;
  logic [CODE_W-1:0] cmd_code;
  logic [ADDR_W-1:0] cmd_addr, bus_addr;
  logic [DATA_W-1:0] rsp_data, bus_rdata;
  int error_cnt, checked;
  bgdc_ctrl uut (.clk, .rst_n, .mode_special_single_chip(ssc), .mode_emulation(emul), .secured,
    .nvm_erase_test_failed(efail), .wait_mode, .stop_mode, .sw_enable_wr(wr_en), .sw_enable_val(sw_val),
    .sw_wait_run_wr(wr_wait), .sw_wait_run_val(sw_val), .sw_clock_sel_wr(wr_clk),
    .sw_clock_sel_val(sw_val), .cmd_valid, .cmd_is_fw, .cmd_code, .cmd_addr, .cmd_wdata(16'h0000),
    .cmd_ready, .rsp_valid, .rsp_error, .rsp_data, .ack_pulse(), .bus_free, .bus_rdata, .bus_req,
    .bus_we(), .bus_word(), .bus_addr, .bus_wdata(), .fw_done, .fw_exit, .fw_start, .fw_entry(),
    .background_enabled(en), .background_active(act), .debug_clock_source_select(csel),
    .wait_run_enable(wrun));
  bgdc_sys_model u_sys (.clk, .rst_n, .exit_sel, .bus_req, .fw_start, .bus_addr, .bus_free,
    .fw_done, .fw_exit, .bus_rdata);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task cyc;
    @(posedge clk);
    #1;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize;
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task rst(input logic s, input logic e);
    rst_n = 0;
    ssc = s;
    emul = e;
    repeat (10) cyc;
    rst_n = 1;
    repeat (3) cyc;
    chk(en, s | e);
    chk(act, s);
    chk(csel, e);
  endtask
  // Holds the request until taken, then waits for the answer, never a fixed delay
  task cmd(input logic fw, input logic [3:0] c, input logic [22:0] a, output logic e,
           output logic [15:0] d);
    int n;
    cmd_valid = 1;
    cmd_is_fw = fw;
    cmd_code = c;
    cmd_addr = a;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      cyc;
      n++;
    end
    if (n >= 50) error_cnt++;
    cyc;
    cmd_valid = 0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 50) begin
      cyc;
      n++;
    end
    if (n >= 50) error_cnt++;
    e = rsp_error;
    d = rsp_data;
    cyc;
  endtask
  task t_normal;
    logic e;
    logic [15:0] d;
    rst(0, 0);
    cmd(1, 4'h0, 0, e, d);
    chk(e, 1'b1);
    sw_val = 1;
    wr_en = 1;
    cyc;
    wr_en = 0;
    sw_val = 0;
    chk(en, 1'b1);
    cmd(0, 4'h0, 0, e, d);
    chk({e, act}, 2'h1);
    cmd(0, 4'h4, 23'h400010, e, d);
    chk({e, d}, 17'h0EF10);
    cmd(0, 4'h9, 0, e, d);
    chk(e, 1'b1);
    cmd(0, 4'h3, FAMILY_ID_ADDR, e, d);
    chk(d, {8'h00, FAMILY_ID_DEFAULT});
    cmd(0, 4'h7, 23'h00000F, e, d);
    chk(d, {8'h00, FAMILY_ID_DEFAULT});
  endtask
  task t_emul;
    rst(0, 1);
    wr_clk = 1;
    cyc;
    wr_clk = 0;
    cyc;
    chk(csel, 1'b0);
    wait_mode = 1;
    repeat (4) cyc;
    chk(cmd_ready, 1'b0);
    wr_wait = 1;
    sw_val = 1;
    cyc;
    wr_wait = 0;
    repeat (3) cyc;
    chk({wrun, cmd_ready}, 2'h3);
    wait_mode = 0;
  endtask
  task t_ssc;
    logic e;
    logic [15:0] d;
    rst(1, 0);
    cmd(1, 4'hD, 0, e, d);
    chk(e, 1'b0);
    cmd(1, 4'hE, 0, e, d);
    chk(e, 1'b1);
    exit_sel = 1;
    cmd(1, 4'h2, 0, e, d);
    chk(act, 1'b0);
    cmd(1, 4'h2, 0, e, d);
    chk(e, 1'b1);
    secured = 1;
    efail = 1;
    cmd(0, 4'h4, 23'h400010, e, d);
    chk(e, 1'b1);
    cmd(0, 4'h4, 23'h000100, e, d);
    chk({e, d}, 17'h0FF00);
    stop_mode = 1;
    repeat (4) cyc;
    chk(cmd_ready, 1'b0);
  endtask
  initial begin
    {rst_n, ssc, emul, secured, efail, wait_mode, stop_mode, exit_sel} = '0;
    {wr_wait, wr_clk, sw_val, cmd_valid, cmd_is_fw, cmd_code, cmd_addr, wr_en} = '0;
    error_cnt = 0;
    checked = 0;
    t_normal;
    t_emul;
    t_ssc;
    summarize;
  end
  // Whole run is well under a thousand cycles
  initial begin
    #100000;
    error_cnt++;
    summarize;
  end
endmodule
bind bgdc_ctrl bgdc_ctrl_props u_props (.clk, .rst_n, .mode_special_single_chip, .mode_emulation,
  .secured, .wait_mode, .stop_mode, .cmd_valid, .cmd_ready, .cmd_is_fw, .rsp_valid, .rsp_error,
  .bus_free, .bus_req, .fw_start, .background_enabled, .background_active,
  .debug_clock_source_select, .wait_run_enable, .cmd_code, .cmd_addr, .rsp_data, .fw_entry);
`default_nettype wire
